// ### scs_pkg.sv
// package: constants and types for the slave acknowledge and control word block
package scs_pkg;

    // ------------------------------------------------------------
    // service channel
    // ------------------------------------------------------------
    localparam logic [15:0] IDN_REF_ACK = 16'h0094;
    localparam logic [31:0] REF_ACK_VALUE = 32'h0000_0000;
    localparam logic [15:0] ERR_SLAVE = 16'h0080;
    localparam logic [15:0] ERR_BAD_SELECTOR = 16'h0001;
    localparam logic [15:0] ERR_BUSY = 16'h0002;
    localparam logic [15:0] ERR_NONE = 16'h0000;

    // ------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------
    localparam int BIT_RT1 = 6;
    localparam int BIT_RT2 = 7;
    localparam int BIT_MODE0 = 8;
    localparam int BIT_MODE1 = 9;
    localparam int BIT_MODE2 = 11;
    localparam int BIT_HALT = 13;
    localparam int BIT_ENABLE = 14;
    localparam int BIT_ON = 15;
    localparam logic [15:0] CTRL_MASK = 16'hEBC0;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    localparam logic [7:0] SEL_DRIVE = 8'h00;
    localparam logic [7:0] SEL_MODE = 8'h01;
    localparam logic [7:0] SEL_RT1 = 8'h02;
    localparam logic [7:0] SEL_RT2 = 8'h03;

    typedef enum logic [1:0] {
        ACK_IDLE,
        ACK_SEND,
        ACK_WAIT
    } scs_ack_state_t;

endpackage : scs_pkg

// ### control_word_composer_word.sv
// control word composer: maps three inputs onto the managed control word bits
`timescale 1ns/1ps
`default_nettype none
module control_word_composer_word (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [7:0] bit_group_selector_i,
    input wire logic control_input_one_i,
    input wire logic control_input_two_i,
    input wire logic control_input_three_i,
    input wire logic blocked_i,
    output logic [15:0] ctrl_word_o,
    output logic write_ok_o,
    output logic [15:0] error_code_o
);
    logic [15:0] word_reg;
    logic [15:0] word_next;
    logic sel_valid;

    // ------------------------------------------------------------
    // next word
    // ------------------------------------------------------------
    always_comb begin
        word_next = word_reg;
        sel_valid = 1'b1;
        case (bit_group_selector_i)
            scs_pkg::SEL_DRIVE: begin
                word_next[scs_pkg::BIT_HALT] = control_input_one_i;
                word_next[scs_pkg::BIT_ENABLE] = control_input_two_i;
                word_next[scs_pkg::BIT_ON] = control_input_three_i;
            end
            scs_pkg::SEL_MODE: begin
                // mode code is {bit 11, bit 9, bit 8}
                word_next[scs_pkg::BIT_MODE0] = control_input_one_i;
                word_next[scs_pkg::BIT_MODE1] = control_input_two_i;
                word_next[scs_pkg::BIT_MODE2] = control_input_three_i;
            end
            scs_pkg::SEL_RT1: begin
                word_next[scs_pkg::BIT_RT1] = control_input_one_i;
            end
            scs_pkg::SEL_RT2: begin
                word_next[scs_pkg::BIT_RT2] = control_input_one_i;
            end
            default: begin
                sel_valid = 1'b0;
            end
        endcase
        word_next = word_next & scs_pkg::CTRL_MASK;
    end

    // ------------------------------------------------------------
    // held word
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            word_reg <= scs_pkg::CTRL_RESET;
        end else if (enable_i && sel_valid && !blocked_i) begin
            word_reg <= word_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            write_ok_o <= 1'b0;
            error_code_o <= scs_pkg::ERR_NONE;
        end else if (enable_i) begin
            write_ok_o <= sel_valid && !blocked_i;
            if (!sel_valid) begin
                error_code_o <= scs_pkg::ERR_BAD_SELECTOR;
            end else if (blocked_i) begin
                error_code_o <= scs_pkg::ERR_BUSY;
            end else begin
                error_code_o <= scs_pkg::ERR_NONE;
            end
        end else begin
            write_ok_o <= 1'b0;
        end
    end

    assign ctrl_word_o = word_reg;
endmodule : control_word_composer_word
`default_nettype wire

// ### scs_slave_ctrl_ack.sv
// top: reference acknowledge unit, control word composer, status and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module scs_slave_ctrl_ack (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // acknowledge request and slave selection
    input wire logic ack_req_i,
    input wire logic [15:0] slot_i,
    input wire logic [15:0] ring_i,
    input wire logic [15:0] slave_i,
    // composer request
    input wire logic ctrl_en_i,
    input wire logic [7:0] bit_group_selector_i,
    input wire logic control_input_one_i,
    input wire logic control_input_two_i,
    input wire logic control_input_three_i,
    output logic ctrl_ok_o,
    output logic [15:0] ctrl_err_o,
    // service channel writer
    output logic sc_wr_o,
    output logic [15:0] sc_slot_o,
    output logic [15:0] sc_ring_o,
    output logic [15:0] sc_slave_o,
    output logic [15:0] sc_idn_o,
    output logic [31:0] sc_data_o,
    input wire logic sc_done_i,
    input wire logic [15:0] sc_err_i,
    input wire logic [15:0] sc_slave_err_i,
    // acknowledge results
    output logic ack_done_o,
    output logic ack_fail_o,
    output logic [15:0] ack_err_o,
    output logic [15:0] ack_slave_err_o,
    output logic master_control_o,
    // cyclic telegram control word
    output logic [15:0] mdt_ctrl_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // register offsets and status bits
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_CLEAR = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_MOTION = 8'h10;
    localparam int ST_DONE = 0;
    localparam int ST_FAIL = 1;
    localparam int ST_CTRL_ERR = 2;

    scs_pkg::scs_ack_state_t state_reg;
    logic req_prev_reg;
    logic req_rise;
    logic [2:0] status_reg;
    logic [2:0] irq_en_reg;
    logic motion_busy_reg;
    logic ctrl_en_prev_reg;
    logic [2:0] events;
    logic [15:0] ctrl_word;

    // ------------------------------------------------------------
    // acknowledge request edge
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            req_prev_reg <= 1'b0;
        end else begin
            req_prev_reg <= ack_req_i;
        end
    end
    assign req_rise = ack_req_i && !req_prev_reg;

    // ------------------------------------------------------------
    // acknowledge sequencer
    // ------------------------------------------------------------
    // the referenced position must already be written by the requester
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= scs_pkg::ACK_IDLE;
            sc_wr_o <= 1'b0;
            sc_slot_o <= 16'h0000;
            sc_ring_o <= 16'h0000;
            sc_slave_o <= 16'h0000;
            sc_idn_o <= 16'h0000;
            sc_data_o <= 32'h0000_0000;
        end else begin
            sc_wr_o <= 1'b0;
            case (state_reg)
                scs_pkg::ACK_IDLE: begin
                    if (req_rise) begin
                        sc_slot_o <= slot_i;
                        sc_ring_o <= ring_i;
                        sc_slave_o <= slave_i;
                        sc_idn_o <= scs_pkg::IDN_REF_ACK;
                        sc_data_o <= scs_pkg::REF_ACK_VALUE;
                        state_reg <= scs_pkg::ACK_SEND;
                    end
                end
                scs_pkg::ACK_SEND: begin
                    sc_wr_o <= 1'b1;
                    state_reg <= scs_pkg::ACK_WAIT;
                end
                scs_pkg::ACK_WAIT: begin
                    if (sc_done_i) begin
                        state_reg <= scs_pkg::ACK_IDLE;
                    end
                end
                default: begin
                    state_reg <= scs_pkg::ACK_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // acknowledge results
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_done_o <= 1'b0;
            ack_fail_o <= 1'b0;
            ack_err_o <= scs_pkg::ERR_NONE;
            ack_slave_err_o <= 16'h0000;
            master_control_o <= 1'b0;
        end else if (req_rise && state_reg == scs_pkg::ACK_IDLE) begin
            ack_done_o <= 1'b0;
            ack_fail_o <= 1'b0;
        end else if (state_reg == scs_pkg::ACK_WAIT && sc_done_i) begin
            ack_done_o <= 1'b1;
            ack_fail_o <= (sc_err_i != scs_pkg::ERR_NONE);
            ack_err_o <= sc_err_i;
            ack_slave_err_o <= (sc_err_i == scs_pkg::ERR_SLAVE) ? sc_slave_err_i : 16'h0000;
            if (sc_err_i == scs_pkg::ERR_NONE) begin
                master_control_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // control word composer
    // ------------------------------------------------------------
    // motion functions own selectors 0 and 1; those writes are refused while the motion busy bit is set
    control_word_composer_word u_ctrl_word (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .enable_i(ctrl_en_i),
        .bit_group_selector_i(bit_group_selector_i),
        .control_input_one_i(control_input_one_i),
        .control_input_two_i(control_input_two_i),
        .control_input_three_i(control_input_three_i),
        .blocked_i(motion_busy_reg && (bit_group_selector_i == scs_pkg::SEL_DRIVE
            || bit_group_selector_i == scs_pkg::SEL_MODE)),
        .ctrl_word_o(ctrl_word),
        .write_ok_o(ctrl_ok_o),
        .error_code_o(ctrl_err_o)
    );
    assign mdt_ctrl_o = ctrl_word;

    // ------------------------------------------------------------
    // status, enable and interrupt
    // ------------------------------------------------------------
    assign events[ST_DONE] = state_reg == scs_pkg::ACK_WAIT && sc_done_i;
    assign events[ST_FAIL] = state_reg == scs_pkg::ACK_WAIT && sc_done_i && sc_err_i != scs_pkg::ERR_NONE;
    // composer result lands one cycle after its enable; flag from the fresh result, not a stale one
    assign events[ST_CTRL_ERR] = ctrl_en_prev_reg && ctrl_err_o != scs_pkg::ERR_NONE;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_en_prev_reg <= 1'b0;
        end else begin
            ctrl_en_prev_reg <= ctrl_en_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status_reg <= 3'h0;
        end else begin
            // a new event wins over a clear in the same cycle
            status_reg <= (status_reg & ~((reg_wr_i && reg_addr_i == OFS_CLEAR) ? reg_wdata_i[2:0] : 3'h0))
                | events;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_en_reg <= 3'h0;
            motion_busy_reg <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == OFS_ENABLE) begin
                irq_en_reg <= reg_wdata_i[2:0];
            end else if (reg_addr_i == OFS_MOTION) begin
                motion_busy_reg <= reg_wdata_i[0];
            end
        end
    end

    assign irq_o = |(status_reg & irq_en_reg);

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            if (reg_addr_i == OFS_STATUS) begin
                reg_rdata_o <= {29'h0000_0000, status_reg};
            end else if (reg_addr_i == OFS_ENABLE) begin
                reg_rdata_o <= {29'h0000_0000, irq_en_reg};
            end else if (reg_addr_i == OFS_CTRL) begin
                reg_rdata_o <= {16'h0000, ctrl_word};
            end else if (reg_addr_i == OFS_MOTION) begin
                reg_rdata_o <= {31'h0000_0000, motion_busy_reg};
            end else begin
                reg_rdata_o <= 32'h0000_0000;
            end
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end
endmodule : scs_slave_ctrl_ack
`default_nettype wire

// ### scs_slave_ctrl_ack_monitor.sv
// checker: port-level properties of the slave acknowledge and control word block
`timescale 1ns/1ps
`default_nettype none
module scs_slave_ctrl_ack_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ctrl_en_i,
    input wire logic [7:0] bit_group_selector_i,
    input wire logic control_input_one_i,
    input wire logic control_input_two_i,
    input wire logic control_input_three_i,
    input wire logic ctrl_ok_o,
    input wire logic [15:0] ctrl_err_o,
    input wire logic sc_wr_o,
    input wire logic [15:0] sc_idn_o,
    input wire logic [31:0] sc_data_o,
    input wire logic sc_done_i,
    input wire logic [15:0] sc_err_i,
    input wire logic [15:0] sc_slave_err_i,
    input wire logic ack_fail_o,
    input wire logic [15:0] ack_err_o,
    input wire logic [15:0] ack_slave_err_o,
    input wire logic master_control_o,
    input wire logic [15:0] mdt_ctrl_o
);
    // one write may be outstanding at the far side
    logic pending_reg;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pending_reg <= 1'b0;
        end else if (sc_wr_o) begin
            pending_reg <= 1'b1;
        end else if (sc_done_i) begin
            pending_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    ack_idn_value_a: assert property (sc_wr_o |-> sc_idn_o == 16'h0094 && sc_data_o == 32'h0000_0000)
        else $error("acknowledge write has wrong idn or data");
    single_write_a: assert property (sc_wr_o |-> !pending_reg)
        else $error("second acknowledge write while one pending");
    fail_flag_a: assert property (sc_done_i && pending_reg |=>
        ack_fail_o == ($past(sc_err_i) != 16'h0000) && ack_err_o == $past(sc_err_i))
        else $error("fail flag or error code wrong");
    slave_err_gate_a: assert property (sc_done_i && pending_reg |=> ack_slave_err_o ==
        ($past(sc_err_i) == 16'h0080 ? $past(sc_slave_err_i) : 16'h0000))
        else $error("slave error code wrong");
    master_back_a: assert property (sc_done_i && pending_reg && sc_err_i == 16'h0000 |=> master_control_o)
        else $error("master control not resumed");
    managed_bits_a: assert property ((mdt_ctrl_o & 16'h143F) == 16'h0000)
        else $error("unmanaged control bit set");
    drive_bits_a: assert property (ctrl_ok_o && $past(ctrl_en_i) && $past(bit_group_selector_i) == 8'h00 |->
        mdt_ctrl_o[15:13] == $past({control_input_three_i, control_input_two_i, control_input_one_i}))
        else $error("drive bits wrong");
    mode_bits_a: assert property (ctrl_ok_o && $past(ctrl_en_i) && $past(bit_group_selector_i) == 8'h01 |->
        {mdt_ctrl_o[11], mdt_ctrl_o[9], mdt_ctrl_o[8]} ==
        $past({control_input_three_i, control_input_two_i, control_input_one_i}))
        else $error("mode bits wrong");
    rt_bit_one_a: assert property (ctrl_ok_o && $past(ctrl_en_i) && $past(bit_group_selector_i) == 8'h02 |->
        mdt_ctrl_o[6] == $past(control_input_one_i) && mdt_ctrl_o[15:7] == $past(mdt_ctrl_o[15:7]))
        else $error("real-time bit one wrong");
    reset_zero_a: assert property ($past(rst_i) |-> mdt_ctrl_o == 16'h0000)
        else $error("control word not zero after reset");
    bad_sel_a: assert property (ctrl_en_i && bit_group_selector_i > 8'h03 |=> !ctrl_ok_o && ctrl_err_o == 16'h0001)
        else $error("bad selector not refused");
    cover property (sc_done_i && pending_reg && sc_err_i == 16'h0080);
    cover property (ctrl_ok_o);
    cover property ($rose(master_control_o));
endmodule : scs_slave_ctrl_ack_monitor
bind scs_slave_ctrl_ack scs_slave_ctrl_ack_monitor i_scs_slave_ctrl_ack_monitor (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ctrl_en_i(ctrl_en_i),
    .bit_group_selector_i(bit_group_selector_i),
    .control_input_one_i(control_input_one_i),
    .control_input_two_i(control_input_two_i),
    .control_input_three_i(control_input_three_i),
    .ctrl_ok_o(ctrl_ok_o),
    .ctrl_err_o(ctrl_err_o),
    .sc_wr_o(sc_wr_o),
    .sc_idn_o(sc_idn_o),
    .sc_data_o(sc_data_o),
    .sc_done_i(sc_done_i),
    .sc_err_i(sc_err_i),
    .sc_slave_err_i(sc_slave_err_i),
    .ack_fail_o(ack_fail_o),
    .ack_err_o(ack_err_o),
    .ack_slave_err_o(ack_slave_err_o),
    .master_control_o(master_control_o),
    .mdt_ctrl_o(mdt_ctrl_o)
);
`default_nettype wire

// ### scs_drive_model.sv
// partner: slave drive answering service channel writes after a set delay
`timescale 1ns/1ps
`default_nettype none
module scs_drive_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic sc_wr_i,
    input wire logic [3:0] delay_i,
    input wire logic [15:0] err_i,
    input wire logic [15:0] slave_err_i,
    output logic sc_done_o,
    output logic [15:0] sc_err_o,
    output logic [15:0] sc_slave_err_o,
    output logic [7:0] writes_o
);
    logic busy_reg;
    logic [3:0] cnt_reg;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
            cnt_reg <= 4'h0;
            sc_done_o <= 1'b0;
            sc_err_o <= 16'h0000;
            sc_slave_err_o <= 16'h0000;
            writes_o <= 8'h00;
        end else begin
            sc_done_o <= 1'b0;
            // error lines mean nothing outside done, so keep them moving
            sc_err_o <= ~sc_err_o;
            sc_slave_err_o <= ~sc_slave_err_o;
            if (sc_wr_i) begin
                busy_reg <= 1'b1;
                cnt_reg <= delay_i;
                writes_o <= writes_o + 8'h01;
            end else if (busy_reg && cnt_reg == 4'h0) begin
                busy_reg <= 1'b0;
                sc_done_o <= 1'b1;
                sc_err_o <= err_i;
                sc_slave_err_o <= slave_err_i;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule : scs_drive_model
`default_nettype wire

// ### scs_slave_ctrl_ack_bench.sv
// testbench: random and corner stimulus for the slave acknowledge and control word block
`timescale 1ns/1ps
`default_nettype none
module scs_slave_ctrl_ack_bench;
    logic clk = 0, rst = 1, wr = 0, rd = 0, req = 0, en = 0, i1 = 0, i2 = 0, i3 = 0;
    logic [7:0] addr = 0, sel = 0, nwr, n0;
    logic [31:0] wdata = 0, rdata, rv, sdata, seed = 32'h0001_1094;
    logic [15:0] slot = 0, ring = 0, slv = 0, derr = 0, dserr = 0, wmodel = 0;
    logic [15:0] cerr, aerr, aserr, sslot, sring, sslv, idn, merr, mserr, mdt;
    logic [3:0] dly = 0;
    logic ok, swr, done, fail, mc, irq, mdone;
    int mismatches = 0, n_compared = 0;
    scs_slave_ctrl_ack i_scs_slave_ctrl_ack (.ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ack_req_i(req),
        .slot_i(slot), .ring_i(ring), .slave_i(slv), .ctrl_en_i(en), .bit_group_selector_i(sel),
        .control_input_one_i(i1), .control_input_two_i(i2), .control_input_three_i(i3),
        .ctrl_ok_o(ok), .ctrl_err_o(cerr), .sc_wr_o(swr), .sc_slot_o(sslot), .sc_ring_o(sring),
        .sc_slave_o(sslv), .sc_idn_o(idn), .sc_data_o(sdata), .sc_done_i(mdone), .sc_err_i(merr),
        .sc_slave_err_i(mserr), .ack_done_o(done), .ack_fail_o(fail), .ack_err_o(aerr),
        .ack_slave_err_o(aserr), .master_control_o(mc), .mdt_ctrl_o(mdt), .irq_o(irq));
    scs_drive_model i_scs_drive_model (.ref_clk_i(clk), .rst_i(rst), .sc_wr_i(swr), .delay_i(dly),
        .err_i(derr), .slave_err_i(dserr), .sc_done_o(mdone), .sc_err_o(merr),
        .sc_slave_err_o(mserr), .writes_o(nwr));
    initial forever #4 clk = ~clk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function logic [15:0] comp(logic [15:0] w, logic [7:0] s, logic [2:0] v);
        case (s)
            8'h00: w[15:13] = v;
            8'h01: {w[11], w[9], w[8]} = v;
            8'h02: w[6] = v[0];
            8'h03: w[7] = v[0];
            default: ;
        endcase
        return w;
    endfunction : comp
    task chk(logic [63:0] got, logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task rw(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        #1 rv = rdata;
    endtask : rw
    task ctl(logic [7:0] s, logic [15:0] e, logic [3:0] v = 4'h0);
        seed = lfsr(seed);
        @(posedge clk);
        en <= 1;
        sel <= s;
        {i3, i2, i1} <= v[3] ? v[2:0] : seed[2:0];
        @(posedge clk);
        en <= 0;
        #1;
        if (e == 0) wmodel = comp(wmodel, s, {i3, i2, i1});
        chk(mdt, wmodel);
        chk(ok, e == 0);
        if (e != 0) chk(cerr, e);
    endtask : ctl
    task ack(logic [15:0] e, logic [15:0] se, logic m);
        seed = lfsr(seed);
        n0 = nwr;
        @(posedge clk);
        req <= 1;
        {ring, slot} <= seed;
        slv <= ~seed[15:0];
        dly <= seed[3:0];
        derr <= e;
        dserr <= se;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 60 && done !== 1'b1 && fail !== 1'b1; k++) @(posedge clk);
        repeat (5) @(posedge clk);
        req <= 0;
        #1 chk(nwr - n0, 1);
        chk({sslot, sring, sslv}, {slot, ring, slv});
        chk({idn, sdata}, {16'h0094, 32'h0});
        chk({fail, aerr}, {e != 0, e});
        chk(aserr, e == 16'h0080 ? se : 16'h0);
        chk(mc, m);
        chk(done, 1);
    endtask : ack
    task report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        rw(0, 8'h0C, 0);
        chk({rv[15:0], mdt}, 0);
        rw(0, 8'hFC, 0);
        chk(rv, 0);
        for (int j = 0; j < 40; j++) begin
            seed = lfsr(seed);
            ctl(j < 4 ? j[7:0] : {6'h0, seed[9:8]}, 0);
        end
        ctl(8'h04, 1);
        ctl(8'hFF, 1);
        rw(0, 8'h0C, 0);
        chk(rv, {16'h0, wmodel});
        rw(1, 8'h10, 1);
        ctl(8'h00, 2);
        ctl(8'h01, 2);
        ctl(8'h03, 0);
        rw(1, 8'h10, 0);
        ctl(8'h00, 0, 4'hF);
        ctl(8'h02, 0, 4'h8);
        ctl(8'h03, 0, 4'h8);
        $display("composer tests done");
        ack(16'h0080, 16'h1234, 0);
        ack(16'h0005, 16'h00AA, 0);
        rw(0, 8'h00, 0);
        chk({rv, irq}, {32'h7, 1'b0});
        rw(1, 8'h08, 7);
        rw(0, 8'h00, 0);
        chk(rv, 0);
        ack(16'h0000, 16'h0000, 1);
        rw(0, 8'h00, 0);
        chk({rv, irq}, {32'h1, 1'b0});
        rw(1, 8'h04, 1);
        chk(irq, 1);
        rw(1, 8'h08, 1);
        chk(irq, 0);
        $display("acknowledge tests done");
        report_and_stop();
    end
endmodule : scs_slave_ctrl_ack_bench
`default_nettype wire
